// ---- sadc_control.sv ----
// converter control: register slave, channel select, approximation sequencer
`timescale 1ns/1ps
module sadc_control
  import sadc_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 lowPowerMode,
  input  wire logic                 compAbove,
  output logic      [1:0]           channelSel,
  output logic      [RES_W-1:0]     ladderCode,
  output logic                      ladderEnable,
  output logic                      converting
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } sadc_state_e;

  sadc_state_e        state_r, state_nxt;
  logic [3:0]         mode_r, mode_nxt;
  logic               start_r, start_nxt;
  logic [RES_W-1:0]   result_r, result_nxt;
  logic [RES_W-1:0]   code_r, code_nxt;
  logic [RES_W-1:0]   bit_r, bit_nxt;
  logic [1:0]         chan_r, chan_nxt;
  logic               ladEn_r, ladEn_nxt;
  logic [31:0]        rdata_r, rdata_nxt;
  logic               wrPend_r, wrPend_nxt;
  logic [ADDR_W-1:0]  wrAddr_r, wrAddr_nxt;
  logic [RES_W-1:0]   stepCode;
  logic               stepTick;
  logic               lastTick;
  logic               addrPhase;
  logic               wrStart;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign channelSel   = chan_r;
  assign ladderCode   = code_r;
  assign ladderEnable = ladEn_r;
  assign converting   = start_r;

  sadc_sar_step #(.W(RES_W)) u_step (
    .trialCode (code_r),
    .trialBit  (bit_r),
    .compAbove (compAbove),
    .nextCode  (stepCode)
  );

  sadc_pace u_pace (
    .core_clk   (core_clk),
    .rst        (rst),
    // stalls in low power and until the ladder is back on, so no step sees it off
    .run        ((state_r == ST_CONV) && ladEn_r && !lowPowerMode),
    .longPeriod (mode_r[PERIOD_BIT]),
    .stepTick   (stepTick),
    .lastTick   (lastTick)
  );

  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  // start bit written as a word during the data phase
  assign wrStart   = wrPend_r && (wrAddr_r == ADDR_START) && hwdata[START_BIT];

  // bus slave: zero-wait, writes land in data phase, reads registered
  always_comb begin
    wrPend_nxt = addrPhase && hwrite;
    wrAddr_nxt = haddr[ADDR_W-1:0];
    rdata_nxt  = rdata_r;
    if (addrPhase && !hwrite) begin
      unique case (haddr[ADDR_W-1:0])
        // digits at consecutive addresses; msbs in high digit
        ADDR_RES_LO: rdata_nxt = {28'h0000000, result_r[DIGIT_W-1:0]};
        ADDR_RES_HI: rdata_nxt = {28'h0000000, result_r[RES_W-1:DIGIT_W]};
        ADDR_START:  rdata_nxt = {29'h0000000, start_r, 2'b00};
        default:     rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // sequencer
  always_comb begin
    state_nxt  = state_r;
    mode_nxt   = mode_r;
    start_nxt  = start_r;
    result_nxt = result_r;
    code_nxt   = code_r;
    bit_nxt    = bit_r;
    chan_nxt   = chan_r;
    if (wrPend_r && wrAddr_r == ADDR_MODE) begin
      // unused bit 1 dropped on write
      mode_nxt = {hwdata[CHAN_HI_BIT], hwdata[CHAN_LO_BIT], 1'b0, hwdata[PERIOD_BIT]};
    end
    case (state_r)
      ST_IDLE: begin
        // start on selected channel; not in low power
        if (wrStart && !lowPowerMode) begin
          start_nxt = 1'b1;
          state_nxt = ST_CONV;
          chan_nxt  = {mode_r[CHAN_HI_BIT], mode_r[CHAN_LO_BIT]};
          code_nxt  = {1'b1, {(RES_W-1){1'b0}}};
          bit_nxt   = {1'b1, {(RES_W-1){1'b0}}};
        end
      end
      ST_CONV: begin
        // frozen while oscillator clock is stopped
        if (!lowPowerMode) begin
          if (stepTick) begin
            code_nxt = stepCode | (bit_r >> 1);
            bit_nxt  = bit_r >> 1;
          end
          if (lastTick) begin
            state_nxt = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // store and self-clear; result held until the next conversion reaches ST_DONE
        result_nxt = code_r;
        start_nxt  = 1'b0;
        state_nxt  = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // ladder cut in low power
    // on from the start edge; after low power it costs one extra stalled cycle
    ladEn_nxt  = !lowPowerMode && (state_nxt == ST_CONV);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      mode_r   <= MODE_RESET;
      start_r  <= 1'b0;
      code_r   <= '0;
      bit_r    <= '0;
      chan_r   <= 2'b00;
      ladEn_r  <= 1'b0;
      rdata_r  <= 32'h00000000;
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
    end else begin
      state_r  <= state_nxt;
      mode_r   <= mode_nxt;
      start_r  <= start_nxt;
      code_r   <= code_nxt;
      bit_r    <= bit_nxt;
      chan_r   <= chan_nxt;
      ladEn_r  <= ladEn_nxt;
      rdata_r  <= rdata_nxt;
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
    end
  end

  // result kept across reset: no reset branch
  always_ff @(posedge core_clk) begin
    result_r <= result_nxt;
  end
endmodule // sadc_control

// ---- sadc_pkg.sv ----
// shared constants for the successive-approximation converter control block
package sadc_pkg;
  // register byte addresses: printed offsets are not word multiples, so index times four
  localparam logic [7:0]  IDX_MODE       = 8'h16;
  localparam logic [7:0]  IDX_RES_LO     = 8'h17;
  localparam logic [7:0]  IDX_RES_HI     = 8'h18;
  localparam logic [7:0]  IDX_START      = 8'h20;
  localparam logic [9:0]  ADDR_MODE      = {IDX_MODE, 2'b00};
  localparam logic [9:0]  ADDR_RES_LO    = {IDX_RES_LO, 2'b00};
  localparam logic [9:0]  ADDR_RES_HI    = {IDX_RES_HI, 2'b00};
  localparam logic [9:0]  ADDR_START     = {IDX_START, 2'b00};
  localparam int          ADDR_W         = 10;
  // mode register fields, plus the start bit of the start register
  localparam int          PERIOD_BIT     = 0;
  localparam int          CHAN_LO_BIT    = 2;
  localparam int          CHAN_HI_BIT    = 3;
  localparam logic [3:0]  MODE_RESET     = 4'h0;
  localparam int          START_BIT      = 2;
  // result layout
  localparam int          RES_W          = 8;
  localparam int          DIGIT_W        = 4;
  localparam logic [7:0]  RES_RESET      = 8'h80;
  // conversion periods in instruction cycles, their counter width, and the bus nonsequential transfer code
  localparam int          CONV_SHORT_CYC = 34;
  localparam int          CONV_LONG_CYC  = 67;
  localparam int          CNT_W          = 7;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
endpackage

// ---- sadc_sar_step.sv ----
// one successive-approximation step: keep or drop the trial bit
`timescale 1ns/1ps
module sadc_sar_step #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] trialCode,
  input  wire logic [W-1:0] trialBit,
  input  wire logic         compAbove,
  output logic      [W-1:0] nextCode
);
  // comparator high means input is below the ladder tap
  always_comb begin
    nextCode = compAbove ? (trialCode & ~trialBit) : trialCode;
  end
endmodule // sadc_sar_step

// ---- sadc_pace.sv ----
// paces the approximation steps one every fourth cycle over the first 32 cycles, then idles to the end of the selected period
`timescale 1ns/1ps
module sadc_pace
  import sadc_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             longPeriod,
  output logic                  stepTick,
  output logic                  lastTick
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] span;
  always_comb begin
    span    = longPeriod ? CNT_W'(CONV_LONG_CYC - 1) : CNT_W'(CONV_SHORT_CYC - 1);
    // held while stalled; >= so a period change mid-conversion cannot run past the end
    lastTick = run && (cnt_r >= span);
    if (!run) begin
      cnt_nxt = cnt_r;
    end else if (lastTick) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
    // one step every fourth cycle, after a settling lead-in
    stepTick = run && (cnt_r[1:0] == 2'b11) && (cnt_r < CNT_W'(4 * RES_W));
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // sadc_pace

// ---- sadc_control_chk.sv ----
// port-level checks for the converter control block
`timescale 1ns/1ps
module sadc_control_chk
  import sadc_pkg::*;
(
  input logic        core_clk,
  input logic        rst,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        lowPowerMode,
  input logic [1:0]  channelSel,
  input logic [7:0]  ladderCode,
  input logic        ladderEnable,
  input logic        converting
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       rdOp;
  logic [6:0] runCnt_r;
  logic [6:0] runCnt_nxt;
  assign rdOp = hsel && hready && htrans == 2'b10 && !hwrite;
  // only cycles in which the pacing counter advances, so frozen ones drop out
  always_comb runCnt_nxt = converting ? runCnt_r + 7'(ladderEnable && !lowPowerMode) : 7'h00;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) runCnt_r <= 7'h00;
    else runCnt_r <= runCnt_nxt;
  sequence s_startWr;
    hsel && hready && htrans == 2'b10 && hwrite && haddr == 32'h80 && !converting
      && !lowPowerMode ##1 hwdata[2] && !lowPowerMode;
  endsequence
  sequence s_flagRd;
    rdOp && haddr == 32'h80;
  endsequence
  a_start_launches: assert property (
    s_startWr |-> ##[1:2] converting) else $error("start write did not launch");
  a_period_length: assert property (
    $fell(converting) |-> runCnt_r == 7'(CONV_SHORT_CYC) || runCnt_r == 7'(CONV_LONG_CYC))
    else $error("conversion length wrong");
  a_flag_readback: assert property (
    s_flagRd |=> hrdata[2] == $past(converting)) else $error("start flag read wrong");
  a_channel_held: assert property (
    converting |=> $stable(channelSel)) else $error("channel moved mid conversion");
  a_ladder_cutoff: assert property (
    lowPowerMode |=> !ladderEnable) else $error("ladder on in low power");
  a_idle_ladder: assert property (
    !converting |-> !ladderEnable) else $error("ladder on while idle");
  a_freeze_code: assert property (
    lowPowerMode |=> $stable(ladderCode)) else $error("code moved in low power");
  a_msb_first: assert property (
    $rose(converting) |-> ##[0:3] ladderCode == 8'h80) else $error("first trial not msb");
  a_mode_unread: assert property (
    rdOp && haddr == 32'h58 |=> hrdata == 32'h0) else $error("mode readable");
endmodule // sadc_control_chk

bind sadc_control sadc_control_chk i_chk (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .lowPowerMode, .channelSel, .ladderCode, .ladderEnable,
  .converting);

// ---- sadc_analog_model.sv ----
// comparator and input multiplexer standing in for the analog side
`timescale 1ns/1ps
module sadc_analog_model #(
  parameter logic [31:0] LEVELS = 32'hFFC35A00
) (
  input  logic       core_clk,
  input  logic [1:0] channelSel,
  input  logic [7:0] ladderCode,
  input  logic       ladderEnable,
  output logic       compAbove
);
  logic [7:0] level;
  logic       noise_r = 1'b0;
  assign level = LEVELS[{channelSel, 3'b000} +: 8];
  always_ff @(posedge core_clk) noise_r <= !noise_r;
  assign compAbove = ladderEnable ? (level < ladderCode) : noise_r;
endmodule // sadc_analog_model

// ---- test_sar_adc_control.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_sar_adc_control;
  import sadc_pkg::*;
  localparam logic [31:0] LEVELS = 32'hFFC35A00;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        lowPowerMode = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        compAbove;
  logic        ladderEnable;
  logic        converting;
  logic [1:0]  channelSel;
  logic [7:0]  ladderCode;
  logic [31:0] rdVal;
  int          fails = 0;
  int          samplesChecked = 0;
  int          cyc = 0;
  int          convCycles = 0;
  sadc_control i_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lowPowerMode, .compAbove,
    .channelSel, .ladderCode, .ladderEnable, .converting);
  sadc_analog_model #(.LEVELS(LEVELS)) i_model (.core_clk, .channelSel, .ladderCode,
    .ladderEnable, .compAbove);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (converting === 1'b1) convCycles <= convCycles + 1;
    if (cyc == 4000) begin
      fails++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ahb(input logic wr, input logic [9:0] addr, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {22'h0, addr};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rdVal = hrdata;
  endtask
  task automatic conv(input logic [1:0] ch, input logic per, input logic lp);
    logic [7:0] lvl;
    lvl = LEVELS[{ch, 3'b000} +: 8];
    convCycles <= 0;
    ahb(1'b1, ADDR_MODE, {28'h0, ch, 1'b0, per});
    ahb(1'b1, ADDR_START, 32'h4); // start written only while idle
    // a mode write mid conversion must not move the channel
    if (ch == 2'h1) ahb(1'b1, ADDR_MODE, {28'h0, 2'h2, 1'b0, per});
    if (ch == 2'h1) ahb(1'b0, ADDR_START, 32'h0);
    if (ch == 2'h1) chk("flag set", rdVal, 32'h4);
    @(posedge core_clk);
    chk("channel", {30'h0, channelSel}, {30'h0, ch});
    lowPowerMode <= lp;
    repeat (10) @(posedge core_clk);
    if (lp) chk("ladder", {31'h0, ladderEnable}, 32'h0);
    lowPowerMode <= 1'b0;
    do ahb(1'b0, ADDR_START, 32'h0); while (rdVal[START_BIT] !== 1'b0);
    // done cycle, plus ten frozen and one ladder restart cycle in low power
    chk("period", 32'(convCycles), (per ? CONV_LONG_CYC : CONV_SHORT_CYC) + (lp ? 12 : 1));
    ahb(1'b0, ADDR_RES_LO, 32'h0);
    chk("low digit", rdVal, {28'h0, lvl[3:0]});
    ahb(1'b0, ADDR_RES_HI, 32'h0);
    chk("high digit", rdVal, {28'h0, lvl[7:4]});
  endtask
  task automatic close_out;
    if (fails == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    ahb(1'b0, ADDR_MODE, 32'h0);
    chk("mode read", rdVal, 32'h0);
    chk("okay response", {31'h0, hresp}, 32'h0);
    ahb(1'b0, 10'h100, 32'h0);
    chk("unmapped", rdVal, 32'h0);
    for (int ch = 0; ch < 4; ch++) conv(2'(ch), ch[0], ch == 2);
    ahb(1'b1, ADDR_RES_LO, 32'h0);
    ahb(1'b0, ADDR_RES_LO, 32'h0);
    chk("read only", rdVal, 32'hF);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    ahb(1'b0, ADDR_RES_HI, 32'h0);
    chk("kept over reset", rdVal, 32'hF);
    close_out();
  end
endmodule // test_sar_adc_control
